// ---- inc/cia_cfg.svh ----
`ifndef CIA_CFG_SVH
`define CIA_CFG_SVH

// channel count and split between the two status registers
`define CIA_NCHAN        12
`define CIA_HALF         6
// register port addresses
`define CIA_ADDR_EN_LO   8'h60
`define CIA_ADDR_STAT_LO 8'h61
`define CIA_ADDR_EN_HI   8'he0
`define CIA_ADDR_STAT_HI 8'he1
// source-level status sits at this offset in each channel page
`define CIA_SRC_OFS      4'h2
`define CIA_LAST_PAGE    4'hb
// reset and filler values
`define CIA_RSV_ZERO     2'h0
`define CIA_EN_RST       12'h000
`define CIA_DATA_ZERO    8'h00

`endif

// ---- inc/cia_pkg.sv ----
package cia_pkg;

	// one host register access, taken on a clock edge
	typedef struct packed {
		logic       rd;
		logic       wr;
		logic [7:0] addr;
		logic [7:0] wdata;
	} cia_req_s;

	// state of the aggregator top
	typedef struct packed {
		logic [11:0] en;
		logic [7:0]  rdata;
		logic        rvalid;
		logic        irq;
	} cia_top_s;

	// state of one channel flag
	typedef struct packed {
		logic pend;
	} cia_flag_s;

endpackage : cia_pkg

// ---- core/cia_chan_flag.sv ----
`timescale 1ns/10ps
`include "cia_cfg.svh"

module cia_chan_flag (
	input  wire logic clk_in,
	input  wire logic rst_in,
	input  wire logic set_in,
	input  wire logic clr_in,
	output logic      flag_out
);

	cia_pkg::cia_flag_s st_q;
	cia_pkg::cia_flag_s st_d;

	// --------------------------------
	// sticky flag, set beats clear
	// --------------------------------
	always_comb begin
		st_d = st_q;
		if (set_in) begin
			st_d.pend = 1'b1;
		end else if (clr_in) begin
			st_d.pend = 1'b0;
		end
	end

	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			st_q <= '0;
		end else begin
			st_q <= st_d;
		end
	end

	assign flag_out = st_q.pend;

	// --------------------------------
	// checks
	// --------------------------------
	property p_flag_set;
		@(posedge clk_in) disable iff (rst_in)
		set_in |=> flag_out;
	endproperty
	a_flag_set: assert property (p_flag_set) else $error("flag not set by event");

	property p_flag_hold;
		@(posedge clk_in) disable iff (rst_in)
		(flag_out && !clr_in) |=> flag_out;
	endproperty
	a_flag_hold: assert property (p_flag_hold) else $error("flag dropped without clear");

	property p_flag_clr;
		@(posedge clk_in) disable iff (rst_in)
		(clr_in && !set_in) |=> !flag_out;
	endproperty
	a_flag_clr: assert property (p_flag_clr) else $error("flag not cleared by read");

endmodule : cia_chan_flag

// ---- core/cia_top.sv ----
// How it works
// - channels 0 to 5 flags appear in bits 0 to 5 of low status register
// - channels 6 to 11 flags appear in bits 0 to 5 of high status register
// - bits 7 and 6 of both status registers hold no channel data
// - flag reads 1 while a channel interrupt is pending, else 0
// - status registers are read-only; writes leave flags untouched
// - a set flag holds until the channel source status register is read
// - per-channel master enable gates that channel onto the interrupt output
`timescale 1ns/10ps
`include "cia_cfg.svh"

module cia_top (
	input  wire logic        MCLK_IN,
	input  wire logic        RST_IN,
	input  wire logic        RD_IN,
	input  wire logic        WR_IN,
	input  wire logic [7:0]  ADDR_IN,
	input  wire logic [7:0]  WDATA_IN,
	input  wire logic [11:0] CHAN_SRC_IRQ_IN,
	output logic      [7:0]  RDATA_OUT,
	output logic             RVALID_OUT,
	output logic      [11:0] SRC_RD_OUT,
	output logic             IRQ_OUT
);

	cia_pkg::cia_req_s req;
	cia_pkg::cia_top_s st_q;
	cia_pkg::cia_top_s st_d;
	logic [11:0]       flags;
	logic [11:0]       clr;

	assign req.rd    = RD_IN;
	assign req.wr    = WR_IN;
	assign req.addr  = ADDR_IN;
	assign req.wdata = WDATA_IN;

	// --------------------------------
	// source status read decode
	// --------------------------------
	// a read of page n offset 2 is the host servicing channel n; the data
	// itself comes from the channel's own source logic, not from here
	always_comb begin
		clr = '0;
		if (req.rd && req.addr[3:0] == `CIA_SRC_OFS && req.addr[7:4] <= `CIA_LAST_PAGE) begin
			clr[req.addr[7:4]] = 1'b1;
		end
	end

	assign SRC_RD_OUT = clr;

	// --------------------------------
	// per-channel sticky flags
	// --------------------------------
	genvar g;
	generate
		for (g = 0; g < `CIA_NCHAN; g++) begin : g_chan
			cia_chan_flag u_flag (
				.clk_in   (MCLK_IN),
				.rst_in   (RST_IN),
				.set_in   (CHAN_SRC_IRQ_IN[g]),
				.clr_in   (clr[g]),
				.flag_out (flags[g])
			);
		end
	endgenerate

	// --------------------------------
	// register port and interrupt
	// --------------------------------
	always_comb begin
		st_d        = st_q;
		st_d.rvalid = req.rd;
		st_d.rdata  = `CIA_DATA_ZERO;
		if (req.wr) begin
			unique case (req.addr)
				`CIA_ADDR_EN_LO: st_d.en[5:0]  = req.wdata[5:0];
				`CIA_ADDR_EN_HI: st_d.en[11:6] = req.wdata[5:0];
				default: ; // status and unmapped writes ignored
			endcase
		end
		if (req.rd) begin
			unique case (req.addr)
				`CIA_ADDR_EN_LO:   st_d.rdata = {`CIA_RSV_ZERO, st_q.en[5:0]};
				`CIA_ADDR_EN_HI:   st_d.rdata = {`CIA_RSV_ZERO, st_q.en[11:6]};
				`CIA_ADDR_STAT_LO: st_d.rdata = {`CIA_RSV_ZERO, flags[5:0]};
				`CIA_ADDR_STAT_HI: st_d.rdata = {`CIA_RSV_ZERO, flags[11:6]};
				default: st_d.rdata = `CIA_DATA_ZERO;
			endcase
		end
		// masked channels never reach the host line
		st_d.irq = |(flags & st_q.en);
	end

	always_ff @(posedge MCLK_IN) begin
		if (RST_IN) begin
			st_q        <= '0;
			st_q.en     <= `CIA_EN_RST;
		end else begin
			st_q <= st_d;
		end
	end

	assign RDATA_OUT  = st_q.rdata;
	assign RVALID_OUT = st_q.rvalid;
	assign IRQ_OUT    = st_q.irq;

	// --------------------------------
	// checks
	// --------------------------------
	sequence s_rd_lo;
		RD_IN && ADDR_IN == `CIA_ADDR_STAT_LO;
	endsequence

	sequence s_rd_hi;
		RD_IN && ADDR_IN == `CIA_ADDR_STAT_HI;
	endsequence

	property p_stat_lo;
		@(posedge MCLK_IN) disable iff (RST_IN)
		s_rd_lo |=> RVALID_OUT && RDATA_OUT[5:0] == $past(flags[5:0]);
	endproperty
	a_stat_lo: assert property (p_stat_lo) else $error("low status mismatch");

	property p_stat_hi;
		@(posedge MCLK_IN) disable iff (RST_IN)
		s_rd_hi |=> RVALID_OUT && RDATA_OUT[5:0] == $past(flags[11:6]);
	endproperty
	a_stat_hi: assert property (p_stat_hi) else $error("high status mismatch");

	property p_rsv_zero;
		@(posedge MCLK_IN) disable iff (RST_IN)
		(s_rd_lo or s_rd_hi) |=> RDATA_OUT[7:6] == `CIA_RSV_ZERO;
	endproperty
	a_rsv_zero: assert property (p_rsv_zero) else $error("reserved bits nonzero");

	property p_ro;
		@(posedge MCLK_IN) disable iff (RST_IN)
		(WR_IN && !RD_IN && CHAN_SRC_IRQ_IN == '0) |=> flags == $past(flags);
	endproperty
	a_ro: assert property (p_ro) else $error("write changed status flags");

	property p_irq_mask;
		@(posedge MCLK_IN) disable iff (RST_IN)
		(st_q.en == '0) |=> !IRQ_OUT;
	endproperty
	a_irq_mask: assert property (p_irq_mask) else $error("masked channel raised interrupt");

	property p_irq_on;
		@(posedge MCLK_IN) disable iff (RST_IN)
		|(flags & st_q.en) |=> IRQ_OUT;
	endproperty
	a_irq_on: assert property (p_irq_on) else $error("enabled pending flag not signalled");

	property p_src_clr;
		@(posedge MCLK_IN) disable iff (RST_IN)
		(RD_IN && ADDR_IN == {4'h3, `CIA_SRC_OFS} && !CHAN_SRC_IRQ_IN[3]) |=> !flags[3];
	endproperty
	a_src_clr: assert property (p_src_clr) else $error("source read did not clear flag");

	property p_flag_pend;
		@(posedge MCLK_IN) disable iff (RST_IN)
		CHAN_SRC_IRQ_IN[0] ##1 (!clr[0])[*2] |-> flags[0];
	endproperty
	a_flag_pend: assert property (p_flag_pend) else $error("pending flag lost");

	// --------------------------------
	// event, clear and port checks
	// --------------------------------
	sequence s_src_rd_any;
		RD_IN && ADDR_IN[3:0] == `CIA_SRC_OFS && ADDR_IN[7:4] <= `CIA_LAST_PAGE;
	endsequence

	property p_set_all;
		@(posedge MCLK_IN) disable iff (RST_IN)
		1'b1 |=> ($past(CHAN_SRC_IRQ_IN) & ~flags) == '0;
	endproperty
	a_set_all: assert property (p_set_all) else $error("event did not set its flag");

	property p_hold_all;
		@(posedge MCLK_IN) disable iff (RST_IN)
		1'b1 |=> ($past(flags) & ~$past(clr) & ~flags) == '0;
	endproperty
	a_hold_all: assert property (p_hold_all) else $error("flag dropped without read");

	property p_clr_all;
		@(posedge MCLK_IN) disable iff (RST_IN)
		1'b1 |=> ($past(clr) & ~$past(CHAN_SRC_IRQ_IN) & flags) == '0;
	endproperty
	a_clr_all: assert property (p_clr_all) else $error("source read left flag set");

	property p_src_rd_gate;
		@(posedge MCLK_IN) disable iff (RST_IN)
		!RD_IN |-> SRC_RD_OUT == '0;
	endproperty
	a_src_rd_gate: assert property (p_src_rd_gate) else $error("strobe without read");

	property p_src_rd_one;
		@(posedge MCLK_IN) disable iff (RST_IN)
		s_src_rd_any |-> SRC_RD_OUT == (12'h001 << ADDR_IN[7:4]);
	endproperty
	a_src_rd_one: assert property (p_src_rd_one) else $error("wrong channel strobed");

	property p_stat_keep;
		@(posedge MCLK_IN) disable iff (RST_IN)
		(s_rd_lo or s_rd_hi) |=> ($past(flags) & ~flags) == '0;
	endproperty
	a_stat_keep: assert property (p_stat_keep) else $error("status read cleared flag");

	property p_irq_off;
		@(posedge MCLK_IN) disable iff (RST_IN)
		!(|(flags & st_q.en)) |=> !IRQ_OUT;
	endproperty
	a_irq_off: assert property (p_irq_off) else $error("interrupt without enabled flag");

	property p_en_lo;
		@(posedge MCLK_IN) disable iff (RST_IN)
		(WR_IN && ADDR_IN == `CIA_ADDR_EN_LO) |=> st_q.en[5:0] == $past(WDATA_IN[5:0]);
	endproperty
	a_en_lo: assert property (p_en_lo) else $error("low enable write lost");

	property p_en_hi;
		@(posedge MCLK_IN) disable iff (RST_IN)
		(WR_IN && ADDR_IN == `CIA_ADDR_EN_HI) |=> st_q.en[11:6] == $past(WDATA_IN[5:0]);
	endproperty
	a_en_hi: assert property (p_en_hi) else $error("high enable write lost");

endmodule : cia_top

// ---- testbench/cia_host_model.sv ----
`timescale 1ns/10ps
`include "cia_cfg.svh"

module cia_host_model (
	input  wire logic       clk_in,
	input  wire logic [7:0] rdata_in,
	input  wire logic       rvalid_in,
	output logic            rd_out,
	output logic            wr_out,
	output logic      [7:0] addr_out,
	output logic      [7:0] wdata_out
);
	// released lines show inverted values, never a stale copy
	initial begin
		rd_out = 1'b0;
		wr_out = 1'b0;
		addr_out = 8'h00;
		wdata_out = 8'h00;
	end

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk_in) #1;
		wr_out = 1'b1;
		addr_out = a;
		wdata_out = d;
		@(posedge clk_in) #1;
		wr_out = 1'b0;
		addr_out = ~a;
		wdata_out = ~d;
	endtask : wr

	task automatic rd(input logic [7:0] a, output logic [7:0] d, output logic v);
		@(posedge clk_in) #1;
		rd_out = 1'b1;
		addr_out = a;
		@(posedge clk_in) #1;
		rd_out = 1'b0;
		addr_out = ~a;
		d = rdata_in;
		v = rvalid_in;
	endtask : rd

	// service step: fetch the cause from the channel page
	task automatic isr(input logic [3:0] ch, output logic [7:0] d, output logic v);
		rd({ch, `CIA_SRC_OFS}, d, v);
	endtask : isr
endmodule : cia_host_model

// ---- testbench/cia_top_tb_top.sv ----
`timescale 1ns/10ps
`include "cia_cfg.svh"

module cia_top_tb_top;
	logic        clk = 1'b0;
	logic        rst = 1'b1;
	logic        rd, wr, rvalid, irq, v;
	logic [7:0]  addr, wdata, rdata, d, a, e;
	logic [11:0] src = 12'h000;
	logic [11:0] src_rd;
	logic [11:0] src_cap = 12'h000;
	logic [11:0] es;
	int          failures = 0;
	int          num_checks = 0;

	always #12.5 clk = ~clk;

	cia_top u_dut (.MCLK_IN(clk), .RST_IN(rst), .RD_IN(rd), .WR_IN(wr), .ADDR_IN(addr),
		.WDATA_IN(wdata), .CHAN_SRC_IRQ_IN(src), .RDATA_OUT(rdata), .RVALID_OUT(rvalid),
		.SRC_RD_OUT(src_rd), .IRQ_OUT(irq));
	cia_host_model u_host (.clk_in(clk), .rdata_in(rdata), .rvalid_in(rvalid), .rd_out(rd),
		.wr_out(wr), .addr_out(addr), .wdata_out(wdata));

	// last source-read strobe seen with a read, zero after any other read
	always @(posedge clk) begin
		if (rd) begin
			src_cap <= src_rd;
		end
	end

	task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
		num_checks++;
		if (seen !== exp) begin
			failures++;
			$display("MISMATCH %s expected %h seen %h", what, exp, seen);
		end
	endtask : check

	task automatic pulse(input int n);
		@(posedge clk) #1;
		src = 12'h001 << n;
		@(posedge clk) #1;
		src = 12'h000;
	endtask : pulse

	task automatic test_done();
		$display("checks %0d mismatches %0d", num_checks, failures);
		if (failures == 0 && num_checks > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask : test_done

	// -------------------------
	// watchdog: run needs ~190 cycles
	// -------------------------
	initial begin
		#(3000 * 25);
		failures++;
		test_done();
	end

	initial begin
		repeat (20) @(posedge clk);
		#1 rst = 1'b0;
		u_host.rd(`CIA_ADDR_STAT_LO, d, v);
		check("stat_lo_rst", d, 8'h00);
		check("rvalid", {7'h00, v}, 8'h01);
		u_host.rd(`CIA_ADDR_STAT_HI, d, v);
		check("stat_hi_rst", d, 8'h00);
		$display("test reset done");
		for (int n = 0; n < `CIA_NCHAN; n++) begin
			a = (n < `CIA_HALF) ? `CIA_ADDR_STAT_LO : `CIA_ADDR_STAT_HI;
			e = 8'h01 << (n % `CIA_HALF);
			pulse(n);
			u_host.rd(a, d, v);
			check("flag", d, e);
			u_host.wr(a, 8'hc0);
			u_host.rd(a, d, v);
			check("flag_ro", d, e);
			u_host.isr(n[3:0], d, v);
			check("src_page", d, 8'h00);
			check("src_valid", {7'h00, v}, 8'h01);
			es = 12'h001 << n;
			check("src_rd_lo", src_cap[7:0], es[7:0]);
			check("src_rd_hi", {4'h0, src_cap[11:8]}, {4'h0, es[11:8]});
			u_host.rd(a, d, v);
			check("flag_clr", d, 8'h00);
		end
		$display("test flags done");
		// enable only channel 3, then fire 3 and 4
		u_host.wr(`CIA_ADDR_EN_LO, 8'h08);
		u_host.rd(`CIA_ADDR_EN_LO, d, v);
		check("en_lo", d, 8'h08);
		pulse(3);
		repeat (2) @(posedge clk);
		#1;
		check("irq_on", {7'h00, irq}, 8'h01);
		u_host.isr(4'h3, d, v);
		repeat (2) @(posedge clk);
		#1;
		check("irq_off", {7'h00, irq}, 8'h00);
		pulse(4);
		repeat (2) @(posedge clk);
		#1;
		check("irq_masked", {7'h00, irq}, 8'h00);
		// upper half: channel 4 stays pending but masked
		u_host.wr(`CIA_ADDR_EN_HI, 8'hff);
		u_host.rd(`CIA_ADDR_EN_HI, d, v);
		check("en_hi", d, 8'h3f);
		pulse(11);
		repeat (2) @(posedge clk);
		#1;
		check("irq_hi", {7'h00, irq}, 8'h01);
		$display("test irq done");
		test_done();
	end
endmodule : cia_top_tb_top
